//--- src/reference_homing_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module reference_homing_sequencer #(
  parameter int NUM_IN = 4,
  parameter int NUM_OUT = 2,
  parameter int TICK_CYCLES = homing_pkg::TICK_CYCLES
) (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Control inputs and their configuration
  input wire logic [NUM_IN-1:0] ctrl_in,
  input wire logic [NUM_IN-1:0][3:0] in_func_in,
  input wire logic [NUM_IN-1:0] in_config_in,
  // Other commands and configuration
  input wire logic decouple_in,
  input wire logic direction_in,
  input wire logic jog_cmd_in,
  input wire logic reset_static_in,
  input wire homing_pkg::home_cfg_t cfg_in,
  // Coupled frequency path and differential counter
  input wire logic [31:0] follow_freq_in,
  input wire logic [31:0] diff_count_in,
  // Serial register access
  input wire homing_pkg::ser_wr_t ser_wr_in,
  input wire homing_pkg::ser_rd_t ser_rd_in,
  output logic [15:0] rd_data_out,
  // Status outputs
  input wire logic [NUM_OUT-1:0][3:0] out_func_in,
  input wire logic [NUM_OUT-1:0] out_pol_in,
  output logic [NUM_OUT-1:0] status_out,
  // Drive
  output logic [31:0] freq_out,
  output logic dir_out,
  output logic phase_err_out,
  output logic busy_out
);
  import homing_pkg::*;

  if (NUM_IN < 1 || NUM_OUT < 1 || TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_chk
    $error("reference_homing_sequencer: unsupported parameter values");
  end

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  typedef struct packed {
    home_state_t state;
    logic [31:0] freq;
    logic dir;
    logic [15:0] tick_cnt;
    logic limit_prev;
    logic homing_prev;
    logic jog_prog;
    logic phase_err;
    logic [15:0] homing_reg;
    logic [15:0] edge_pol_reg;
    logic [15:0] rd_data;
    logic [NUM_OUT-1:0] status;
  } st_t;

  st_t r;
  st_t n;

  logic homing_cmd;
  logic edge_pol;
  logic limit;
  logic trig_first;
  logic trig_second;
  logic start;
  logic move;
  logic abort;
  logic busy;
  logic [31:0] high_mhz;
  logic [31:0] low_mhz;
  logic [31:0] step_high;
  logic [31:0] step_low;

  // Command level from every control input assigned to a function
  function automatic logic in_cmd(input logic [3:0] fn, input logic [NUM_IN-1:0] lvl,
                                  input logic [NUM_IN-1:0][3:0] fns,
                                  input logic [NUM_IN-1:0] cfg);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (fns[i] == fn) begin
        hit = hit | (cfg[i] ? lvl[i] : ~lvl[i]);
      end
    end
    return hit;
  endfunction : in_cmd

  function automatic logic ser_hit(input ser_wr_t w, input logic [15:0] mb,
                                   input logic [15:0] code);
    return w.valid && (w.modbus ? (w.addr == mb) : (w.addr == code));
  endfunction : ser_hit

  // Only 0 and 1 are meaningful; other values leave the command as it was
  function automatic logic [15:0] ser_level(input logic [15:0] cur, input logic [15:0] d);
    if (d == CMD_SET || d == CMD_RELEASE) begin
      return d;
    end
    return cur;
  endfunction : ser_level

  // Per-millisecond step in mHz; a zero ramp time gives the whole speed at once
  function automatic logic [31:0] ramp_step(input logic [19:0] speed_hz,
                                            input logic [15:0] ramp_s);
    logic [31:0] q;
    q = 32'(speed_hz) / 32'(ramp_s == 16'h0000 ? 16'h0001 : ramp_s);
    if (ramp_s == 16'h0000) begin
      return 32'(speed_hz) * MHZ_PER_HZ;
    end
    return (q == 32'h0000_0000) ? 32'h0000_0001 : q;
  endfunction : ramp_step

  function automatic logic [31:0] ramp_toward(input logic [31:0] f, input logic [31:0] tgt,
                                              input logic [31:0] step);
    logic [32:0] sum;
    sum = {1'b0, f} + {1'b0, step};
    return (sum >= {1'b0, tgt}) ? tgt : sum[31:0];
  endfunction : ramp_toward

  function automatic logic status_fn(input logic [3:0] fn, input st_t s, input logic bsy,
                                     input logic rst_static);
    unique case (fn)
      OUT_FN_PHASE_ERR: return s.phase_err;
      OUT_FN_DIRECTION: return s.dir;
      OUT_FN_RESET_STATIC: return rst_static;
      OUT_FN_HOMING_PROG: return bsy;
      OUT_FN_MOVING: return (s.freq != 32'h0000_0000) || bsy;
      OUT_FN_ABOVE_ZERO: return s.freq != 32'h0000_0000;
      OUT_FN_JOG_PROG: return s.jog_prog;
      default: return 1'b0;
    endcase
  endfunction : status_fn

  always_comb begin
    homing_cmd = r.homing_reg[0] | in_cmd(IN_FN_HOMING, ctrl_in, in_func_in, in_config_in);
    edge_pol = r.edge_pol_reg[0] | in_cmd(IN_FN_EDGE_POL, ctrl_in, in_func_in, in_config_in);
    limit = in_cmd(IN_FN_LIMIT, ctrl_in, in_func_in, in_config_in);
    trig_first = edge_pol ? (r.limit_prev & ~limit) : (~r.limit_prev & limit);
    trig_second = edge_pol ? (~r.limit_prev & limit) : (r.limit_prev & ~limit);
    // Homing is taken only while decoupled, so a missed decouple cannot fight the coupled path
    start = homing_cmd & ~r.homing_prev & decouple_in;
    busy = !(r.state inside {ST_IDLE, ST_DONE});
    abort = busy && !homing_cmd && (cfg_in.special_mode == SPECIAL_ABORT);
    move = (r.tick_cnt == TICK_LAST) || (cfg_in.ramp_s == 16'h0000);
    high_mhz = 32'(cfg_in.speed_high_hz) * MHZ_PER_HZ;
    low_mhz = 32'(cfg_in.speed_low_hz) * MHZ_PER_HZ;
    step_high = ramp_step(cfg_in.speed_high_hz, cfg_in.ramp_s);
    step_low = ramp_step(cfg_in.speed_low_hz, cfg_in.ramp_s);
  end

  always_comb begin
    n = r;
    if (ce_in) begin
      n.tick_cnt = (r.tick_cnt == TICK_LAST) ? 16'h0000 : r.tick_cnt + 16'h0001;
      n.limit_prev = limit;
      n.homing_prev = homing_cmd;
      // Serial commands stay as levels until a zero is written
      if (ser_hit(ser_wr_in, MB_HOMING, CODE_HOMING)) begin
        n.homing_reg = ser_level(r.homing_reg, ser_wr_in.data);
      end
      if (ser_hit(ser_wr_in, MB_EDGE_POL, CODE_EDGE_POL)) begin
        n.edge_pol_reg = ser_level(r.edge_pol_reg, ser_wr_in.data);
      end
      if (ser_rd_in.valid) begin
        if (ser_rd_in.modbus ? ser_rd_in.addr == MB_HOMING : ser_rd_in.addr == CODE_HOMING) begin
          n.rd_data = r.homing_reg;
        end else if (ser_rd_in.modbus ? ser_rd_in.addr == MB_EDGE_POL
                                      : ser_rd_in.addr == CODE_EDGE_POL) begin
          n.rd_data = r.edge_pol_reg;
        end else begin
          n.rd_data = 16'h0000;
        end
      end
      n.phase_err = diff_count_in > cfg_in.diff_limit;
      n.jog_prog = jog_cmd_in | (r.jog_prog && r.freq != 32'h0000_0000);
      unique case (r.state)
        ST_IDLE: begin
          n.freq = decouple_in ? MIN_FREQ_MHZ : follow_freq_in;
          n.dir = direction_in;
          if (start) begin
            n.state = ST_RAMP_UP;
            n.freq = 32'h0000_0000;
            n.tick_cnt = 16'h0000;
          end
        end
        ST_RAMP_UP: begin
          if (trig_first) begin
            n.state = ST_RAMP_DOWN;
          end else if (move) begin
            n.freq = ramp_toward(r.freq, high_mhz, step_high);
            if (n.freq == high_mhz) begin
              n.state = ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          n.freq = high_mhz;
          if (trig_first) begin
            n.state = ST_RAMP_DOWN;
          end
        end
        ST_RAMP_DOWN: begin
          if (r.freq == 32'h0000_0000) begin
            n.state = ST_REV_UP;
            n.dir = ~r.dir;
          end else if (move) begin
            n.freq = (r.freq > step_high) ? r.freq - step_high : 32'h0000_0000;
          end
        end
        ST_REV_UP: begin
          if (trig_second) begin
            n.state = ST_DONE;
            n.freq = 32'h0000_0000;
          end else if (move) begin
            n.freq = ramp_toward(r.freq, low_mhz, step_low);
            if (n.freq == low_mhz) begin
              n.state = ST_REV_HOLD;
            end
          end
        end
        ST_REV_HOLD: begin
          n.freq = low_mhz;
          if (trig_second) begin
            n.state = ST_DONE;
            n.freq = 32'h0000_0000;
          end
        end
        ST_DONE: begin
          n.freq = 32'h0000_0000;
          if (!homing_cmd) begin
            n.state = ST_IDLE;
          end
        end
        default: begin
          n.state = ST_IDLE;
          n.freq = 32'h0000_0000;
        end
      endcase
      // Without the abort mode an early release is ignored until the cycle ends
      if (abort) begin
        n.state = ST_IDLE;
        n.freq = 32'h0000_0000;
      end
      for (int i = 0; i < NUM_OUT; i++) begin
        n.status[i] = status_fn(out_func_in[i], r, busy, reset_static_in) ^ out_pol_in[i];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '{state: ST_IDLE, homing_reg: CMD_RESET_VAL, edge_pol_reg: CMD_RESET_VAL,
             default: '0};
    end else begin
      r <= n;
    end
  end

  assign freq_out = r.freq;
  assign dir_out = r.dir;
  assign phase_err_out = r.phase_err;
  assign busy_out = busy;
  assign rd_data_out = r.rd_data;
  assign status_out = r.status;

  // Checks
  sequence s_first_edge;
    ce_in && r.state inside {ST_RAMP_UP, ST_HOLD} && trig_first && !abort;
  endsequence

  sequence s_second_edge;
    ce_in && r.state inside {ST_REV_UP, ST_REV_HOLD} && trig_second && !abort;
  endsequence

  AST_FIRST_EDGE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_first_edge |=> r.state == ST_RAMP_DOWN && r.freq == $past(r.freq))
    else $error("first limit edge did not start the ramp down");

  AST_STOP_ABRUPT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_second_edge |=> r.state == ST_DONE && r.freq == 32'h0000_0000)
    else $error("second limit edge did not stop the output");

  AST_REVERSE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ce_in && r.state == ST_RAMP_DOWN && r.freq == 32'h0000_0000 && !abort
    |=> r.state == ST_REV_UP && r.dir != $past(r.dir))
    else $error("direction not reversed at zero");

  AST_EDGE_POL: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ce_in && r.state == ST_HOLD && !abort && r.limit_prev != limit
    |=> r.state == (($past(limit) != $past(edge_pol)) ? ST_RAMP_DOWN : ST_HOLD))
    else $error("limit edge polarity not honoured in hold");

  AST_JUMP: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ce_in && r.state == ST_RAMP_UP && cfg_in.ramp_s == 16'h0000 && !trig_first && !abort
    |=> r.freq == $past(high_mhz) && r.state == ST_HOLD)
    else $error("zero ramp time did not jump to high speed");

  AST_ABORT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ce_in && abort |=> r.state == ST_IDLE ##1 !ce_in || r.freq != 32'h0000_0000 || !decouple_in)
    else $error("early release in abort mode did not end the cycle");

  AST_DECOUPLE_MIN: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ce_in && r.state == ST_IDLE && decouple_in && !start |=> r.freq == MIN_FREQ_MHZ)
    else $error("decoupled idle frequency is not the minimum");

  AST_MODBUS_SET: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ce_in && ser_wr_in.valid && ser_wr_in.modbus && ser_wr_in.addr == MB_HOMING
    && ser_wr_in.data == CMD_SET |=> r.homing_reg == CMD_SET ##1 homing_cmd || !ce_in
    || ser_wr_in.valid)
    else $error("homing register write not held");

  AST_CODE_SET: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ce_in && ser_wr_in.valid && !ser_wr_in.modbus && ser_wr_in.addr == CODE_EDGE_POL
    |=> r.edge_pol_reg == ser_level($past(r.edge_pol_reg), $past(ser_wr_in.data)))
    else $error("edge polarity code write mishandled");

  AST_PHASE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ce_in && diff_count_in > cfg_in.diff_limit |=> phase_err_out)
    else $error("phase error not raised");

  AST_PROGRESS: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ce_in && r.state == ST_IDLE && start |=> busy_out [*2])
    else $error("homing progress not shown after start");

endmodule : reference_homing_sequencer
`default_nettype wire

//--- src/homing_pkg.sv
package homing_pkg;

  // Clock and millisecond ramp tick
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_TIME_NS = 1_000_000;
  localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Control input functions
  localparam logic [3:0] IN_FN_HOMING = 4'h6;
  localparam logic [3:0] IN_FN_LIMIT = 4'h9;
  localparam logic [3:0] IN_FN_EDGE_POL = 4'hA;

  // Serial addresses: character protocol codes and Modbus registers
  localparam logic [15:0] CODE_EDGE_POL = 16'h003F;
  localparam logic [15:0] CODE_HOMING = 16'h0040;
  localparam logic [15:0] MB_HOMING = 16'hFF10;
  localparam logic [15:0] MB_EDGE_POL = 16'hFF14;
  localparam logic [15:0] CMD_RELEASE = 16'h0000;
  localparam logic [15:0] CMD_SET = 16'h0001;
  localparam logic [15:0] CMD_RESET_VAL = 16'h0000;

  // Status output functions
  localparam logic [3:0] OUT_FN_PHASE_ERR = 4'h2;
  localparam logic [3:0] OUT_FN_DIRECTION = 4'h3;
  localparam logic [3:0] OUT_FN_RESET_STATIC = 4'h4;
  localparam logic [3:0] OUT_FN_HOMING_PROG = 4'h5;
  localparam logic [3:0] OUT_FN_MOVING = 4'h6;
  localparam logic [3:0] OUT_FN_ABOVE_ZERO = 4'h7;
  localparam logic [3:0] OUT_FN_JOG_PROG = 4'h8;

  // Special mode value that turns an early release into an abort
  localparam logic [3:0] SPECIAL_ABORT = 4'h2;

  // Lowest output frequency while decoupled and idle, in millihertz (0.1 Hz)
  localparam logic [31:0] MIN_FREQ_MHZ = 32'h0000_0064;
  localparam logic [31:0] MHZ_PER_HZ = 32'h0000_03E8;

  typedef struct packed {
    logic [15:0] ramp_s;
    logic [19:0] speed_high_hz;
    logic [19:0] speed_low_hz;
    logic [3:0] special_mode;
    logic [31:0] diff_limit;
  } home_cfg_t;

  typedef struct packed {
    logic valid;
    logic modbus;
    logic [15:0] addr;
    logic [15:0] data;
  } ser_wr_t;

  typedef struct packed {
    logic valid;
    logic modbus;
    logic [15:0] addr;
  } ser_rd_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RAMP_UP = 7'h02,
    ST_HOLD = 7'h04,
    ST_RAMP_DOWN = 7'h08,
    ST_REV_UP = 7'h10,
    ST_REV_HOLD = 7'h20,
    ST_DONE = 7'h40
  } home_state_t;

endpackage : homing_pkg

//--- test/limit_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module limit_drive_model (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Drive from the sequencer
  input wire logic [31:0] freq_in,
  input wire logic dir_in,
  // Test set-up
  input wire logic clear_in,
  input wire logic [63:0] trip_in,
  input wire logic invert_in,
  // Limit switch level
  output logic limit_out
);
  logic signed [63:0] pos_reg;
  // Position integrates the output frequency; direction 1 runs backwards
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos_reg <= '0;
    end else if (clear_in) begin
      pos_reg <= '0;
    end else if (dir_in) begin
      pos_reg <= pos_reg - $signed({32'h0000_0000, freq_in});
    end else begin
      pos_reg <= pos_reg + $signed({32'h0000_0000, freq_in});
    end
  end
  // Contact closes past the trip point; an inverted contact reads the other way
  assign limit_out = (pos_reg >= $signed(trip_in)) ^ invert_in;
endmodule : limit_drive_model
`default_nettype wire

//--- test/tb_reference_homing_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_reference_homing_sequencer;
  import homing_pkg::*;
  localparam int TICK = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic home_lvl, edge_lvl, lim, decouple, direction, reset_static;
  logic [3:0] ctrl;
  logic [3:0][3:0] in_func;
  logic [3:0] in_cfg;
  home_cfg_t cfg;
  logic [31:0] follow, diff, freq;
  ser_wr_t wr_s;
  ser_rd_t rd_s;
  logic [15:0] rd_data;
  logic [1:0][3:0] out_func;
  logic [1:0] out_pol, status;
  logic dir, phase_err, busy, clr, inv;
  logic jog, ce;
  logic [63:0] trip;
  int fails = 0;
  int tests_run = 0;

  assign ctrl = {1'b0, edge_lvl, lim, home_lvl};
  always #20 clk = ~clk;

  reference_homing_sequencer #(.TICK_CYCLES(TICK)) DUT (
    .sys_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
    .ctrl_in(ctrl), .in_func_in(in_func), .in_config_in(in_cfg),
    .decouple_in(decouple), .direction_in(direction), .jog_cmd_in(jog),
    .reset_static_in(reset_static), .cfg_in(cfg), .follow_freq_in(follow),
    .diff_count_in(diff), .ser_wr_in(wr_s), .ser_rd_in(rd_s), .rd_data_out(rd_data),
    .out_func_in(out_func), .out_pol_in(out_pol), .status_out(status), .freq_out(freq),
    .dir_out(dir), .phase_err_out(phase_err), .busy_out(busy)
  );

  limit_drive_model drive (
    .sys_clk_in(clk), .rst_n_in(rst_n), .freq_in(freq), .dir_in(dir),
    .clear_in(clr), .trip_in(trip), .invert_in(inv), .limit_out(lim)
  );

  task automatic chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  // Samples land 1 ns after the edge so every update of that edge is settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic mb, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_s <= '{1'b1, mb, a, d};
    @(posedge clk);
    wr_s.valid <= 1'b0;
    #1;
  endtask : wr

  task automatic rd_chk(input logic mb, input logic [15:0] a, input logic [15:0] e);
    @(posedge clk);
    rd_s <= '{1'b1, mb, a};
    @(posedge clk);
    rd_s.valid <= 1'b0;
    cyc(1);
    chk(rd_data === e, "read back");
  endtask : rd_chk

  task automatic wait_freq(input logic [31:0] f, input int n, input string m);
    for (int i = 0; i < n && freq !== f; i++) cyc(1);
    chk(freq === f, m);
  endtask : wait_freq

  task automatic wait_lim(input logic v, input int n);
    for (int i = 0; i < n && lim !== v; i++) cyc(1);
    chk(lim === v, "limit switch");
  endtask : wait_lim

  // Exactly one ramp tick falls in any window of TICK cycles
  task automatic chk_step(input int d, input string m);
    logic [31:0] f0;
    f0 = freq;
    cyc(TICK);
    chk((freq - f0) === 32'(d), m);
  endtask : chk_step

  task automatic setup(input logic [15:0] ramp, input logic [63:0] tr, input logic iv);
    @(posedge clk);
    cfg.ramp_s <= ramp;
    trip <= tr;
    inv <= iv;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask : setup

  task automatic t_regs;
    cyc(3);
    chk(freq === 32'h0000_3039, "follow path");
    rd_chk(1'b1, MB_HOMING, CMD_RESET_VAL);
    wr(1'b1, MB_HOMING, CMD_SET);
    rd_chk(1'b0, CODE_HOMING, CMD_SET);
    wr(1'b1, MB_HOMING, 16'h0002);
    rd_chk(1'b1, MB_HOMING, CMD_SET);
    wr(1'b0, CODE_EDGE_POL, CMD_SET);
    rd_chk(1'b1, MB_EDGE_POL, CMD_SET);
    wr(1'b1, MB_EDGE_POL, CMD_RELEASE);
    rd_chk(1'b0, CODE_EDGE_POL, CMD_RELEASE);
    wr(1'b0, CODE_HOMING, CMD_RELEASE);
    rd_chk(1'b1, MB_HOMING, CMD_RELEASE);
    rd_chk(1'b1, 16'h1234, 16'h0000);
    @(posedge clk);
    decouple <= 1'b1;
    cyc(3);
    chk(freq === MIN_FREQ_MHZ, "decoupled minimum");
  endtask : t_regs

  task automatic t_static;
    @(posedge clk);
    out_func <= {OUT_FN_RESET_STATIC, OUT_FN_PHASE_ERR};
    out_pol <= 2'b10;
    diff <= 32'h0000_0064;
    cyc(3);
    chk(phase_err === 1'b0 && status === 2'b10, "at limit");
    @(posedge clk);
    diff <= 32'h0000_0065;
    reset_static <= 1'b1;
    cyc(3);
    chk(phase_err === 1'b1 && status === 2'b01, "over limit");
    @(posedge clk);
    diff <= 32'h0000_0000;
    reset_static <= 1'b0;
    out_pol <= 2'b00;
  endtask : t_static

  // Jog progress stays up until the output frequency has dropped to zero
  task automatic t_jog;
    @(posedge clk);
    out_func <= {OUT_FN_ABOVE_ZERO, OUT_FN_JOG_PROG};
    jog <= 1'b1;
    @(posedge clk);
    jog <= 1'b0;
    cyc(4);
    chk(status === 2'b11, "jog progress held");
    @(posedge clk);
    decouple <= 1'b0;
    follow <= 32'h0000_0000;
    cyc(4);
    chk(freq === 32'h0000_0000 && status === 2'b00, "jog progress over");
    @(posedge clk);
    decouple <= 1'b1;
    follow <= 32'h0000_3039;
    cyc(3);
  endtask : t_jog

  task automatic t_jump(input logic mb, input logic pol);
    setup(16'h0000, 64'h0000_0000_000F_4240, pol);
    out_func <= {OUT_FN_ABOVE_ZERO, OUT_FN_HOMING_PROG};
    if (mb) begin
      wr(mb, MB_EDGE_POL, {15'h0000, pol});
    end else begin
      edge_lvl <= pol;
    end
    wr(mb, mb ? MB_HOMING : CODE_HOMING, CMD_SET);
    wait_freq(32'h0000_4E20, 5, "jump to high");
    cyc(20);
    chk(freq === 32'h0000_4E20 && busy && status === 2'b11 && !dir, "hold");
    wait_lim(~pol, 300);
    wait_freq(32'h0000_0000, 6, "jump to zero");
    wait_freq(32'h0000_1388, 6, "jump to low");
    cyc(2);
    chk(dir === 1'b1 && status === 2'b11, "reversed");
    wait_lim(pol, 300);
    for (int i = 0; i < 4 && freq === 32'h0000_1388; i++) cyc(1);
    chk(freq === 32'h0000_0000, "abrupt stop");
    cyc(2);
    chk(busy === 1'b0 && status === 2'b00, "cycle over");
    wr(mb, mb ? MB_HOMING : CODE_HOMING, CMD_RELEASE);
    cyc(3);
    chk(freq === MIN_FREQ_MHZ && status === 2'b10, "idle minimum");
    @(posedge clk);
    edge_lvl <= 1'b0;
    wr(mb, mb ? MB_EDGE_POL : CODE_EDGE_POL, CMD_RELEASE);
  endtask : t_jump

  task automatic t_ramp;
    setup(16'h0001, 64'h0000_0000_0393_8700, 1'b0);
    out_func <= {OUT_FN_MOVING, OUT_FN_DIRECTION};
    home_lvl <= 1'b0;
    cyc(TICK + 3);
    chk_step(20, "ramp up step");
    wait_freq(32'h0000_4E20, 5000, "high speed");
    cyc(2);
    chk(status === 2'b10 && busy === 1'b1, "moving forward");
    wait_lim(1'b1, 2000);
    cyc(3);
    chk_step(-20, "ramp down step");
    wait_freq(32'h0000_0000, 5000, "down to zero");
    cyc(TICK + 3);
    chk_step(5, "reverse step");
    chk(status === 2'b11, "moving reverse");
    wait_freq(32'h0000_1388, 5000, "low speed");
    wait_lim(1'b0, 8000);
    cyc(3);
    chk(freq === 32'h0000_0000 && busy === 1'b0, "stopped");
    cyc(2);
    chk(status === 2'b01, "stopped reverse");
    @(posedge clk);
    home_lvl <= 1'b1;
  endtask : t_ramp

  task automatic t_early;
    logic [31:0] peak;
    peak = 32'h0000_0000;
    setup(16'h0001, 64'h0000_0000_0003_0D40, 1'b0);
    wr(1'b1, MB_HOMING, CMD_SET);
    wait_lim(1'b1, 1000);
    cyc(3);
    chk_step(-20, "down from present");
    wait_freq(32'h0000_0000, 1000, "early zero");
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
      cyc(1);
      if (freq > peak) peak = freq;
    end
    chk(busy === 1'b0 && freq === 32'h0 && peak < 32'h0000_1388, "early stop");
    wr(1'b1, MB_HOMING, CMD_RELEASE);
  endtask : t_early

  // Release while ramping must abort instead of being ignored
  task automatic t_abort;
    logic [31:0] f0;
    @(posedge clk);
    cfg.special_mode <= SPECIAL_ABORT;
    setup(16'h0001, 64'h0000_0000_0393_8700, 1'b0);
    wr(1'b1, MB_HOMING, CMD_SET);
    cyc(10 * TICK);
    chk(busy === 1'b1 && freq !== 32'h0000_0000, "ramping");
    // A low enable must hold the ramp where it stands
    @(posedge clk);
    ce <= 1'b0;
    cyc(1);
    f0 = freq;
    cyc(2 * TICK);
    chk(freq === f0 && busy === 1'b1, "frozen while disabled");
    @(posedge clk);
    ce <= 1'b1;
    wr(1'b1, MB_HOMING, CMD_RELEASE);
    cyc(3);
    chk(busy === 1'b0 && freq === MIN_FREQ_MHZ, "aborted");
    @(posedge clk);
    cfg.special_mode <= 4'h0;
  endtask : t_abort

  task automatic print_verdict;
    $display("checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    home_lvl = 1'b1;
    edge_lvl = 1'b0;
    in_func = {4'h0, IN_FN_EDGE_POL, IN_FN_LIMIT, IN_FN_HOMING};
    in_cfg = 4'b0110;
    decouple = 1'b0;
    direction = 1'b0;
    reset_static = 1'b0;
    jog = 1'b0;
    ce = 1'b1;
    cfg = '{16'h0000, 20'h0_0014, 20'h0_0005, 4'h0, 32'h0000_0064};
    follow = 32'h0000_3039;
    diff = 32'h0000_0000;
    wr_s = '0;
    rd_s = '0;
    out_func = '0;
    out_pol = 2'b00;
    clr = 1'b0;
    inv = 1'b0;
    trip = 64'h7FFF_FFFF_FFFF_FFFF;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_static();
    t_jog();
    t_jump(1'b1, 1'b0);
    t_jump(1'b0, 1'b1);
    t_ramp();
    t_early();
    t_abort();
    print_verdict();
  end

  // Whole run is near a million ns; four times that means a hang
  initial begin
    #4_000_000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : tb_reference_homing_sequencer
`default_nettype wire
